/* rtl/synth_ctrl_map.svh */
/*
  Bit layout, codes and reset values of the synthesizer configuration words.
  Assumes 24-bit words, destination code in the three lowest bits.
*/
`ifndef SYNTH_CTRL_MAP_SVH
`define SYNTH_CTRL_MAP_SVH

`define WORD_BITS          24
`define CODE_MSB           2
`define CODE_LSB           0

// Destination codes
`define CODE_INT_WORD      3'h0
`define CODE_MOD_WORD      3'h1
`define CODE_FRAC_WORD     3'h2
`define CODE_DITHER_WORD   3'h3
`define CODE_CP_REF        3'h4
`define CODE_LO_PATH       3'h5
`define CODE_VCO_CTRL      3'h6

// Charge pump, phase detector and reference path word
`define CPR_MON_SEL_MSB    23
`define CPR_MON_SEL_LSB    21
`define CPR_REF_SCALE_MSB  20
`define CPR_REF_SCALE_LSB  19
`define CPR_RSET_EXT_BIT   18
`define CPR_OFS_NEG_BIT    17
`define CPR_OFS_MSB        16
`define CPR_OFS_LSB        12
`define CPR_MULT_MSB       11
`define CPR_MULT_LSB       10
`define CPR_RESET          24'h000004

// LO path and demodulator word
`define LOP_BIAS_EN_BIT    3
`define LOP_DIV_BIT        4
`define LOP_DRIVER_BIT     5
`define LOP_EXT_LO_BIT     6
`define LOP_RESET          24'h00000D

// VCO control and enables word
`define VCO_EN_BIT         3
`define VCO_LDO_EN_BIT     4
`define VCO_CP_EN_BIT      5
`define VCO_BAND_SRC_BIT   6
`define VCO_BAND_MSB       12
`define VCO_BAND_LSB       7
`define VCO_AMP_MSB        17
`define VCO_AMP_LSB        13
`define VCO_RESET          24'h03003E

// Divider words
`define INT_MSB            10
`define INT_LSB            3
`define INT_MAX            8'h77
`define MOD_MSB            13
`define MOD_LSB            3
`define MOD_RESET          11'h600
`define FRAC_MSB           13
`define FRAC_LSB           3
`define FRAC_RESET         11'h300
`define INT_RESET          8'h00

// Phase offset step in tenths of a degree
`define OFS_STEP_TENTHS    13'h0E1
// Fixed quadrature divide of the internal synthesizer
`define SYNTH_LO_DIV       3'h4

`endif

/* rtl/synth_ctrl_pkg.sv */
/*
  Types shared by the synthesizer configuration bank.
  Assumes the constants of synth_ctrl_map.svh.
*/
package synth_ctrl_pkg;
  typedef logic [23:0] cfg_word_t;
  typedef logic [2:0]  word_code_t;
  typedef logic [2:0]  mon_sel_t;
  typedef logic [1:0]  ref_scale_t;
endpackage : synth_ctrl_pkg

/* rtl/serial_word_receiver.sv */
/*
  Serial receiver: synchronises the serial clock, data and latch pins,
  shifts data MSB first on each serial clock rise, delivers the word on
  the latch rise once WIDTH bits have come since the last latch. Assumes pins are asynchronous to clk_sys and slower
  than a quarter of it.
*/
`timescale 1ns/10ps
module serial_word_receiver
  import synth_ctrl_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input  wire logic      clk_sys,
  input  wire logic      rst_b,
  input  wire logic      ce,
  input  wire logic      ser_clk_pin,
  input  wire logic      ser_data_pin,
  input  wire logic      ser_latch_pin,
  output cfg_word_t      word_q,
  output logic           word_valid_q
);
  logic [2:0]       pins;
  logic [2:0]       sync1_q;
  logic [2:0]       sync2_q;
  logic [2:0]       last_q;
  logic [WIDTH-1:0] shift_q;
  logic [4:0]       count_q;
  logic             clk_rise;
  logic             latch_rise;

  assign pins = {ser_latch_pin, ser_data_pin, ser_clk_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          last_q[g]  <= 1'b0;
        end else if (ce) begin
          sync1_q[g] <= pins[g];
          sync2_q[g] <= sync1_q[g];
          last_q[g]  <= sync2_q[g];
        end
      end
    end
  endgenerate

  assign clk_rise   = sync2_q[0] & ~last_q[0];
  assign latch_rise = sync2_q[2] & ~last_q[2];

  // Shift, count bits since the last latch
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= '0;
      count_q <= 5'h00;
    end else if (ce) begin
      if (latch_rise) begin
        count_q <= 5'h00;
      end else if (clk_rise) begin
        shift_q <= {shift_q[WIDTH-2:0], sync2_q[1]};
        if (count_q != 5'(WIDTH)) begin
          count_q <= count_q + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      word_q       <= '0;
      word_valid_q <= 1'b0;
    end else if (ce) begin
      word_valid_q <= latch_rise && (count_q == 5'(WIDTH));
      if (latch_rise && (count_q == 5'(WIDTH))) begin
        word_q <= shift_q;
      end
    end
  end
endmodule : serial_word_receiver

/* rtl/monitor_output_mux.sv */
/*
  Monitor output selector: registers one of several internal signals onto
  the monitor pin. Assumes all sources are on clk_sys.
*/
`timescale 1ns/10ps
module monitor_output_mux
  import synth_ctrl_pkg::*;
#(
  parameter int SOURCES = 8
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               ce,
  input  mon_sel_t                sel,
  input  wire logic [SOURCES-1:0] sources,
  output logic                    monitor_output_pin
);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      monitor_output_pin <= 1'b0;
    end else if (ce) begin
      monitor_output_pin <= sources[sel];
    end
  end
endmodule : monitor_output_mux

/* rtl/synth_control_register_bank.sv */
/*
  Synthesizer configuration bank: receives serial words, holds the charge
  pump/reference, LO path and VCO control words plus the divider values,
  and drives the derived controls. Assumes lock detect and the LO select
  pin are asynchronous; calibration result is on clk_sys.
*/
// What this block does
// - Code 100 loads charge pump word
// - DB18 picks internal or external resistor
// - Current multiplier is one plus DB11:DB10
// - Offset 22.5 degrees times value over multiplier
// - DB17 sets offset polarity
// - Reference scaled by 1, 2, 0.5, 0.25
// - Monitor pin selectable, default lock detect
// - LO direction, divide, demodulator bias
// - Code 110 loads VCO control word
// - Band from calibration or written value
// - VCO amplitude 0 to 31, default 24
// - Separate VCO and regulator enables
// - Charge pump enable, default enabled
// - External LO divided by 2 or 4
// - Synth frequency ratio, integer above 119 flagged
// - Internal LO is synthesizer over four
// - 24-bit words, low three bits select
// - Words 0, 1, 2 start calibration
`timescale 1ns/10ps
`include "synth_ctrl_map.svh"
module synth_control_register_bank
  import synth_ctrl_pkg::*;
#(
  parameter int BAND_W = 6
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              ser_clk_pin,
  input  wire logic              ser_data_pin,
  input  wire logic              ser_latch_pin,
  input  wire logic              lock_detect_in,
  input  wire logic              lo_source_select_pin,
  input  wire logic [BAND_W-1:0] cal_band,
  input  wire logic              cal_busy,
  output logic                   monitor_output_pin,
  output logic                   cal_start,
  output logic                   rset_external,
  output logic [2:0]             current_multiplier,
  output logic [4:0]             phase_offset_multiplier,
  output logic                   phase_offset_negative,
  output logic [12:0]            phase_offset_tenths_deg,
  output ref_scale_t             ref_scale,
  output logic [2:0]             ref_mult_num,
  output logic [2:0]             ref_mult_den,
  output logic                   lo_pins_output_en,
  output logic                   lo_predivide_by2,
  output logic [2:0]             ext_lo_divide,
  output logic [2:0]             int_lo_divide,
  output logic                   demod_bias_en,
  output logic                   ext_lo_active,
  output logic                   int_lo_monitor,
  output logic                   vco_en,
  output logic                   vco_ldo_en,
  output logic                   charge_pump_en,
  output logic [BAND_W-1:0]      vco_band,
  output logic [4:0]             vco_amplitude,
  output logic [7:0]             int_ratio,
  output logic [10:0]            mod_value,
  output logic [10:0]            frac_value,
  output logic                   int_ratio_error
);
  cfg_word_t   rx_word;
  logic        rx_valid;
  word_code_t  rx_code;

  cfg_word_t   charge_pump_reference_control_q;
  cfg_word_t   lo_path_demod_control_q;
  cfg_word_t   vco_control_enables_q;
  logic [7:0]  int_q;
  logic [10:0] mod_q;
  logic [10:0] frac_q;

  logic [1:0]  async_in;
  logic [1:0]  meta_q;
  logic [1:0]  stable_q;
  logic        lock_sync;
  logic        lo_source_select_pin_sync;

  logic [7:0]  mon_sources;

  // Multiplier from its two-bit field
  function automatic logic [2:0] mult_of(input logic [1:0] f);
    mult_of = {1'b0, f} + 3'h1;
  endfunction : mult_of

  // Offset magnitude, tenths of a degree, rounded down
  function automatic logic [12:0] offset_tenths(input logic [4:0] ofs,
                                                 input logic [1:0] f);
    logic [12:0] raw;
    raw = 13'(`OFS_STEP_TENTHS * {8'h00, ofs});
    unique case (f)
      2'h0:    offset_tenths = raw;
      2'h1:    offset_tenths = raw >> 1;
      2'h2:    offset_tenths = raw / 13'h0003;
      2'h3:    offset_tenths = raw >> 2;
    endcase
  endfunction : offset_tenths

  serial_word_receiver #(
    .WIDTH         (`WORD_BITS)
  ) u_rx (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .ce            (ce),
    .ser_clk_pin   (ser_clk_pin),
    .ser_data_pin  (ser_data_pin),
    .ser_latch_pin (ser_latch_pin),
    .word_q        (rx_word),
    .word_valid_q  (rx_valid)
  );

  // Destination from the low three bits
  assign rx_code = rx_word[`CODE_MSB:`CODE_LSB];

  // Two-stage synchronisers for asynchronous levels
  assign async_in = {lo_source_select_pin, lock_detect_in};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          meta_q[g]   <= 1'b0;
          stable_q[g] <= 1'b0;
        end else if (ce) begin
          meta_q[g]   <= async_in[g];
          stable_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign lock_sync  = stable_q[0];
  assign lo_source_select_pin_sync = stable_q[1];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      charge_pump_reference_control_q <= `CPR_RESET;
    end else if (ce && rx_valid && rx_code == `CODE_CP_REF) begin
      charge_pump_reference_control_q <= rx_word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lo_path_demod_control_q <= `LOP_RESET;
    end else if (ce && rx_valid && rx_code == `CODE_LO_PATH) begin
      lo_path_demod_control_q <= rx_word;
    end
  end

  // VCO control word, amplitude 24 after reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vco_control_enables_q <= `VCO_RESET;
    end else if (ce && rx_valid && rx_code == `CODE_VCO_CTRL) begin
      vco_control_enables_q <= rx_word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_q  <= `INT_RESET;
      mod_q  <= `MOD_RESET;
      frac_q <= `FRAC_RESET;
    end else if (ce && rx_valid) begin
      if (rx_code == `CODE_INT_WORD) begin
        int_q <= rx_word[`INT_MSB:`INT_LSB];
      end
      if (rx_code == `CODE_MOD_WORD) begin
        mod_q <= rx_word[`MOD_MSB:`MOD_LSB];
      end
      if (rx_code == `CODE_FRAC_WORD) begin
        frac_q <= rx_word[`FRAC_MSB:`FRAC_LSB];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cal_start <= 1'b0;
    end else if (ce) begin
      cal_start <= rx_valid && (rx_code == `CODE_INT_WORD ||
                                rx_code == `CODE_MOD_WORD ||
                                rx_code == `CODE_FRAC_WORD);
    end
  end

  // Charge pump, offset and reference controls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rset_external           <= 1'b0;
      current_multiplier      <= 3'h1;
      phase_offset_multiplier <= 5'h00;
      phase_offset_negative   <= 1'b0;
      phase_offset_tenths_deg <= 13'h0000;
      ref_scale               <= 2'h0;
      ref_mult_num            <= 3'h1;
      ref_mult_den            <= 3'h1;
    end else if (ce) begin
      rset_external <= charge_pump_reference_control_q[`CPR_RSET_EXT_BIT];
      current_multiplier <=
        mult_of(charge_pump_reference_control_q[`CPR_MULT_MSB:`CPR_MULT_LSB]);
      phase_offset_multiplier <=
        charge_pump_reference_control_q[`CPR_OFS_MSB:`CPR_OFS_LSB];
      phase_offset_tenths_deg <= offset_tenths(
        charge_pump_reference_control_q[`CPR_OFS_MSB:`CPR_OFS_LSB],
        charge_pump_reference_control_q[`CPR_MULT_MSB:`CPR_MULT_LSB]);
      phase_offset_negative <= charge_pump_reference_control_q[`CPR_OFS_NEG_BIT];
      ref_scale <=
        charge_pump_reference_control_q[`CPR_REF_SCALE_MSB:`CPR_REF_SCALE_LSB];
      unique case (charge_pump_reference_control_q[`CPR_REF_SCALE_MSB:
                                                   `CPR_REF_SCALE_LSB])
        2'h0: begin
          ref_mult_num <= 3'h1;
          ref_mult_den <= 3'h1;
        end
        2'h1: begin
          ref_mult_num <= 3'h2;
          ref_mult_den <= 3'h1;
        end
        2'h2: begin
          ref_mult_num <= 3'h1;
          ref_mult_den <= 3'h2;
        end
        2'h3: begin
          ref_mult_num <= 3'h1;
          ref_mult_den <= 3'h4;
        end
      endcase
    end
  end

  // LO path controls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lo_pins_output_en <= 1'b0;
      lo_predivide_by2  <= 1'b0;
      ext_lo_divide     <= 3'h2;
      int_lo_divide     <= `SYNTH_LO_DIV;
      demod_bias_en     <= 1'b0;
      ext_lo_active     <= 1'b0;
      int_lo_monitor    <= 1'b0;
    end else if (ce) begin
      lo_pins_output_en <= lo_path_demod_control_q[`LOP_DRIVER_BIT];
      lo_predivide_by2  <= lo_path_demod_control_q[`LOP_DIV_BIT];
      demod_bias_en     <= lo_path_demod_control_q[`LOP_BIAS_EN_BIT];
      // External LO by 2 or 4
      ext_lo_divide <= lo_path_demod_control_q[`LOP_DIV_BIT] ? 3'h4 : 3'h2;
      // Internal LO is synth over four
      int_lo_divide <= `SYNTH_LO_DIV;
      // External LO needs pin low and bits
      ext_lo_active <= ~lo_source_select_pin_sync &
                       ~lo_path_demod_control_q[`LOP_DRIVER_BIT] &
                       lo_path_demod_control_q[`LOP_EXT_LO_BIT];
      int_lo_monitor <= lo_source_select_pin_sync;
    end
  end

  // VCO controls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vco_en         <= 1'b1;
      vco_ldo_en     <= 1'b1;
      charge_pump_en <= 1'b1;
      vco_band       <= '0;
      vco_amplitude  <= 5'h18;
    end else if (ce) begin
      vco_en     <= vco_control_enables_q[`VCO_EN_BIT];
      vco_ldo_en <= vco_control_enables_q[`VCO_LDO_EN_BIT];
      charge_pump_en <= vco_control_enables_q[`VCO_CP_EN_BIT];
      vco_band <= vco_control_enables_q[`VCO_BAND_SRC_BIT] ?
                  BAND_W'(vco_control_enables_q[`VCO_BAND_MSB:`VCO_BAND_LSB]) :
                  cal_band;
      vco_amplitude <= vco_control_enables_q[`VCO_AMP_MSB:`VCO_AMP_LSB];
    end
  end

  // Divider value outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_ratio       <= `INT_RESET;
      mod_value       <= `MOD_RESET;
      frac_value      <= `FRAC_RESET;
      int_ratio_error <= 1'b0;
    end else if (ce) begin
      int_ratio  <= int_q;
      mod_value  <= mod_q;
      frac_value <= frac_q;
      int_ratio_error <= (int_q > `INT_MAX);
    end
  end

  // Monitor sources, code 0 is lock detect
  assign mon_sources = {ext_lo_active, int_ratio_error, cal_busy, 1'b1,
                        1'b0, cal_start, charge_pump_en, lock_sync};

  monitor_output_mux #(
    .SOURCES            (8)
  ) u_mon (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .ce                 (ce),
    .sel                (charge_pump_reference_control_q[`CPR_MON_SEL_MSB:
                                                         `CPR_MON_SEL_LSB]),
    .sources            (mon_sources),
    .monitor_output_pin (monitor_output_pin)
  );
endmodule : synth_control_register_bank

/* tb/synth_host_model.sv */
/*
  Host model: shifts configuration words onto the serial pins, MSB first.
  Assumes clk_sys is the bench clock; clock and latch levels hold 3 cycles, each data bit 7.
*/
`timescale 1ns/10ps
module synth_host_model
  import synth_ctrl_pkg::*;
(
  input  wire logic clk_sys,
  output logic      ser_clk_pin,
  output logic      ser_data_pin,
  output logic      ser_latch_pin
);
  initial begin
    ser_clk_pin = 1'b0;
    ser_data_pin = 1'b0;
    ser_latch_pin = 1'b0;
  end

  task automatic hold3(input logic lvl);
    ser_clk_pin <= lvl;
    repeat (3) @(posedge clk_sys);
  endtask : hold3

  task automatic send_word(input cfg_word_t w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data_pin <= w[i];
      @(posedge clk_sys);
      hold3(1'b1);
      hold3(1'b0);
    end
    ser_latch_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ser_latch_pin <= 1'b0;
    // Released data line stops showing the last bit
    ser_data_pin <= ~w[0];
    repeat (3) @(posedge clk_sys);
  endtask : send_word
endmodule : synth_host_model

/* tb/synth_control_register_bank_chk.sv */
/*
  Port checker for the synthesizer configuration bank.
  Assumes one clock domain; bound to every bank instance below.
*/
`timescale 1ns/10ps
module synth_control_register_bank_chk (
  input wire logic  clk_sys,
  input wire logic  rst_b,
  input wire logic  ser_latch_pin,
  input logic       cal_start,
  input logic [2:0] current_multiplier,
  input logic [4:0] phase_offset_multiplier,
  input logic [12:0] phase_offset_tenths_deg,
  input logic       lo_predivide_by2,
  input logic [2:0] ext_lo_divide,
  input logic [2:0] int_lo_divide,
  input logic [7:0] int_ratio,
  input logic       int_ratio_error,
  input logic [4:0] vco_amplitude,
  input logic       vco_en,
  input logic       vco_ldo_en,
  input logic       charge_pump_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Cycles since the latch pin last rose, saturating
  logic [3:0] since_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      since_q <= 4'hF;
    end else if ($rose(ser_latch_pin)) begin
      since_q <= 4'h1;
    end else if (since_q != 4'hF) begin
      since_q <= since_q + 4'h1;
    end
  end

  sequence pulse_s; cal_start ##1 !cal_start; endsequence
  sequence ofs_steady_s;
    ($stable(current_multiplier) && $stable(phase_offset_multiplier))[*3];
  endsequence
  sequence int_steady_s; $stable(int_ratio)[*2]; endsequence

  cal_pulse_a: assert property (cal_start |-> pulse_s)
    else $error("cal_start longer than one cycle");
  cal_after_latch_a: assert property (cal_start |-> since_q inside {[4'h2:4'h9]})
    else $error("cal_start without a recent latch");
  offset_calc_a: assert property (ofs_steady_s |->
    phase_offset_tenths_deg == 13'h0E1 * phase_offset_multiplier / current_multiplier)
    else $error("phase offset does not match multipliers");
  mult_range_a: assert property (current_multiplier inside {[3'h1:3'h4]})
    else $error("current multiplier out of range");
  ext_div_a: assert property ($stable(lo_predivide_by2)[*2] |->
    ext_lo_divide == (lo_predivide_by2 ? 3'h4 : 3'h2))
    else $error("external LO divide wrong");
  int_lo_div_a: assert property (int_lo_divide == 3'h4)
    else $error("internal LO divide not four");
  int_limit_a: assert property (int_steady_s |-> int_ratio_error == (int_ratio > 8'h77))
    else $error("integer ratio flag wrong");
  reset_values_a: assert property ($rose(rst_b) |-> vco_amplitude == 5'h18 &&
    vco_en && vco_ldo_en && charge_pump_en && current_multiplier == 3'h1)
    else $error("power-up defaults wrong");
endmodule : synth_control_register_bank_chk

bind synth_control_register_bank synth_control_register_bank_chk u_chk (
  .clk_sys, .rst_b, .ser_latch_pin, .cal_start, .current_multiplier,
  .phase_offset_multiplier, .phase_offset_tenths_deg, .lo_predivide_by2,
  .ext_lo_divide, .int_lo_divide, .int_ratio, .int_ratio_error,
  .vco_amplitude, .vco_en, .vco_ldo_en, .charge_pump_en
);

/* tb/test_synth_control_register_bank.sv */
/*
  Bench for the synthesizer configuration bank: words go in through the
  host model and outputs are compared with values worked out here.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/10ps
module test_synth_control_register_bank
  import synth_ctrl_pkg::*;
;
  logic clk_sys, rst_b, ce, lock_detect_in, lo_source_select_pin, cal_busy;
  logic ser_clk_pin, ser_data_pin, ser_latch_pin, monitor_output_pin, cal_start;
  logic rset_external, phase_offset_negative, lo_pins_output_en, lo_predivide_by2;
  logic demod_bias_en, ext_lo_active, int_lo_monitor, vco_en, vco_ldo_en;
  logic charge_pump_en, int_ratio_error;
  logic [2:0]  current_multiplier, ref_mult_num, ref_mult_den, ext_lo_divide, int_lo_divide;
  logic [4:0]  phase_offset_multiplier, vco_amplitude;
  logic [12:0] phase_offset_tenths_deg;
  ref_scale_t  ref_scale;
  logic [5:0]  vco_band, cal_band;
  logic [7:0]  int_ratio;
  logic [10:0] mod_value, frac_value;
  int          miscompares, checked, cycles, cal_cnt, c;

  synth_host_model u_host (.clk_sys, .ser_clk_pin, .ser_data_pin, .ser_latch_pin);

  synth_control_register_bank u_dut (
    .clk_sys, .rst_b, .ce, .ser_clk_pin, .ser_data_pin, .ser_latch_pin,
    .lock_detect_in, .lo_source_select_pin, .cal_band, .cal_busy,
    .monitor_output_pin, .cal_start, .rset_external, .current_multiplier,
    .phase_offset_multiplier, .phase_offset_negative, .phase_offset_tenths_deg,
    .ref_scale, .ref_mult_num, .ref_mult_den, .lo_pins_output_en,
    .lo_predivide_by2, .ext_lo_divide, .int_lo_divide, .demod_bias_en,
    .ext_lo_active, .int_lo_monitor, .vco_en, .vco_ldo_en, .charge_pump_en,
    .vco_band, .vco_amplitude, .int_ratio, .mod_value, .frac_value, .int_ratio_error
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input cfg_word_t w);
    u_host.send_word(w, 24);
    repeat (6) @(posedge clk_sys);
  endtask : wr

  // Calibration pulse count and hang limit
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cal_start === 1'b1) cal_cnt <= cal_cnt + 1;
    if (cycles == 15000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    lock_detect_in = 1'b0;
    lo_source_select_pin = 1'b0;
    cal_busy = 1'b0;
    cal_band = 6'h15;
    {miscompares, checked, cycles, cal_cnt, c} = '0;
    repeat (12) @(posedge clk_sys);
    chk(24'(vco_amplitude), 24'h18);
    chk(24'({vco_en, vco_ldo_en, charge_pump_en}), 24'h7);
    chk(24'(current_multiplier), 24'h1);
    chk(24'({mod_value, frac_value}), 24'h300300);
    rst_b <= 1'b1;
    lock_detect_in <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(24'(monitor_output_pin), 24'h1);
    chk(24'({vco_en, vco_ldo_en, charge_pump_en, vco_amplitude}), 24'hF8);
    lock_detect_in <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(24'(monitor_output_pin), 24'h0);
    wr({6'h00, 5'h1F, 6'h2A, 4'b1010, 3'h6});
    chk(24'(vco_amplitude), 24'h1F);
    chk(24'(vco_band), 24'h2A);
    chk(24'({vco_en, vco_ldo_en, charge_pump_en}), 24'h2);
    wr({6'h00, 5'h00, 6'h3F, 4'b0101, 3'h6});
    chk(24'(vco_band), 24'h15);
    chk(24'({vco_en, vco_ldo_en, charge_pump_en, vco_amplitude}), 24'hA0);
    cal_band <= 6'h0B;
    repeat (4) @(posedge clk_sys);
    chk(24'(vco_band), 24'h0B);
    for (int i = 0; i < 16; i++) begin
      wr({17'h0, 4'(i), 3'h5});
      chk(24'({lo_pins_output_en, lo_predivide_by2, demod_bias_en}), 24'(i % 8));
      chk(24'(ext_lo_divide), i[1] ? 24'h4 : 24'h2);
      chk(24'(ext_lo_active), 24'(i[3] & ~i[2]));
    end
    chk(24'(int_lo_divide), 24'h4);
    // external LO needs the select pin low
    wr({17'h0, 4'b1001, 3'h5});
    lo_source_select_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(24'({ext_lo_active, int_lo_monitor}), 24'h1);
    lo_source_select_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cal_busy <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr({3'(i), 2'(i), i[1], i[0], 5'h1F, 2'(i), 7'h00, 3'h4});
      chk(24'(current_multiplier), 24'(i % 4 + 1));
      chk(24'(phase_offset_tenths_deg), 24'(6975 / (i % 4 + 1)));
      chk(24'({rset_external, phase_offset_negative}), 24'(i % 4));
      chk(24'(ref_scale), 24'(i % 4));
      chk(24'(ref_mult_num), (i % 4 == 1) ? 24'h2 : 24'h1);
      chk(24'(ref_mult_den), (i % 4 == 2) ? 24'h2 : (i % 4 == 3) ? 24'h4 : 24'h1);
      chk(24'(monitor_output_pin), 24'((8'hB2 >> i) & 8'h01));
    end
    chk(24'(phase_offset_multiplier), 24'h1F);
    // Clock enable low freezes the bank
    ce <= 1'b0;
    wr(24'h000004);
    ce <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(24'({current_multiplier, phase_offset_multiplier}), 24'h9F);
    c = cal_cnt;
    u_host.send_word({6'h00, 5'h03, 6'h00, 4'b0101, 3'h6}, 23);
    wr(24'hFFFFFF);
    wr(24'h000003);
    chk(24'(vco_amplitude), 24'h0);
    chk(24'(cal_cnt - c), 24'h0);
    wr({10'h0, 11'h2FF, 3'h2});
    wr({10'h0, 11'h2FF, 3'h2});
    chk(24'(frac_value), 24'h2FF);
    wr({10'h0, 11'h7FF, 3'h1});
    chk(24'(mod_value), 24'h7FF);
    wr({13'h0, 8'h77, 3'h0});
    chk(24'({int_ratio, int_ratio_error}), 24'hEE);
    wr({13'h0, 8'h78, 3'h0});
    chk(24'(int_ratio_error), 24'h1);
    chk(24'(cal_cnt - c), 24'h5);
    complete_run();
  end
endmodule : test_synth_control_register_bank
